//--- hdl/hsp_signal_path.sv
// Operation
// - Low pass filter each Hall sample first
// - Multiply filtered sample by effective gain
// - Add offset after gain multiplication
// - Limit result to 12 bits for DAC
// - Subtract reference temperature from temperature code
// - Linear path multiplies difference by first coefficient
// - Quadratic path squares difference, times second coefficient
// - Effective gain is gain plus both paths
// - Range code selects converter span
// - Gain is (setting minus 16384)/4096
// - Offset is (setting minus 16384)/4096 full scale
// - Offset spans -400 to 399 percent
// - Seven bandwidths, setting 7 bypasses, unity DC gain
// - Filter output is sampled into the buffer at 16 kHz
`timescale 1ns/1ps
module hsp_signal_path
    import hsp_pkg::*;
#(
    parameter int DECIM = DECIM_CYCLES
)
(
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [7:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire logic [HALL_W-1:0]    hall_data_i,
    input  wire logic                 hall_valid_i,
    input  wire logic [TEMP_W-1:0]    temp_data_i,
    input  wire logic                 temp_valid_i,
    output logic      [RANGE_W-1:0]   adc_range_o,
    output logic      [DAC_W-1:0]     dac_code_o,
    output logic                      dac_valid_o,
    input  wire logic                 dac_ready_i
);
    localparam int CNT_W = $clog2(DECIM + 1);
    localparam int PROD_W = HALL_W + GEFF_W;

    // Settings
    logic [RANGE_W-1:0]  range_reg;
    logic [SET_W-1:0]    gain_reg;
    logic [SET_W-1:0]    offset_reg;
    logic [BW_W-1:0]     bw_reg;
    logic [TEMP_W-1:0]   tref_reg;
    logic [COEF_W-1:0]   coef1_reg;
    logic [COEF_W-1:0]   coef2_reg;

    // Bus slave
    logic                wait_reg;
    logic [31:0]         rdata_reg;

    // Temperature compensation
    logic signed [TEMP_W:0]   dt_reg;
    logic                     dt_vld_reg;
    logic signed [31:0]       lin_reg;
    logic signed [31:0]       sq_reg;
    logic                     mul_vld_reg;
    logic signed [31:0]       quad_reg;
    logic                     quad_vld_reg;
    logic signed [GEFF_W-1:0] geff_reg;

    // Decimation
    logic [CNT_W-1:0]         tick_cnt_reg;
    logic                     pend_reg;

    // Field datapath
    hsp_state_e               state_reg;
    hsp_state_e               state_next;
    logic signed [HALL_W-1:0] x_reg;
    logic signed [GEFF_W-1:0] gain_hold_reg;
    logic signed [PROD_W-1:0] prod_reg;
    logic signed [PROD_W:0]   sum_reg;
    logic [DAC_W-1:0]         dac_reg;
    logic                     dac_vld_reg;

    wire  signed [HALL_W-1:0] lpf_y;
    wire         [HALL_W-1:0] fifo_data;
    wire                      fifo_out_valid;
    wire                      fifo_in_ready;
    wire         [3:0]        fifo_count;

    // Bus decode
    wire         req     = avs_read_i | avs_write_i;
    wire         commit  = req & ~wait_reg;
    wire         wr_en   = avs_write_i & commit;
    wire         hit_rng = (avs_address_i == ADDR_RANGE);
    wire         hit_gn  = (avs_address_i == ADDR_GAIN);
    wire         hit_ofs = (avs_address_i == ADDR_OFFSET);
    wire         hit_bw  = (avs_address_i == ADDR_LOWPASS);
    wire         hit_tr  = (avs_address_i == ADDR_TREF);
    wire         hit_t1  = (avs_address_i == ADDR_COEF1);
    wire         hit_t2  = (avs_address_i == ADDR_COEF2);
    wire         hit_st  = (avs_address_i == ADDR_STATUS);
    wire         hit_dac = (avs_address_i == ADDR_DAC);
    wire         hit_ge  = (avs_address_i == ADDR_GEFF);
    wire  [31:0] bmask;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_bmask
            assign bmask[gb*8 +: 8] = {8{avs_byteenable_i[gb]}};
        end
    endgenerate

    wire  [31:0] wmerge_rng = ({30'h0, range_reg} & ~bmask)
                            | (avs_writedata_i & bmask);
    wire  [31:0] wmerge_gn  = ({17'h0, gain_reg} & ~bmask)
                            | (avs_writedata_i & bmask);
    wire  [31:0] wmerge_ofs = ({17'h0, offset_reg} & ~bmask)
                            | (avs_writedata_i & bmask);
    wire  [31:0] wmerge_bw  = ({29'h0, bw_reg} & ~bmask)
                            | (avs_writedata_i & bmask);
    wire  [31:0] wmerge_tr  = ({20'h0, tref_reg} & ~bmask)
                            | (avs_writedata_i & bmask);
    wire  [31:0] wmerge_t1  = ({16'h0, coef1_reg} & ~bmask)
                            | (avs_writedata_i & bmask);
    wire  [31:0] wmerge_t2  = ({16'h0, coef2_reg} & ~bmask)
                            | (avs_writedata_i & bmask);

    wire  [31:0] status_word = {22'h0, state_reg, dac_vld_reg,
                                pend_reg, fifo_count};

    wire  [31:0] rdata_next =
        hit_rng ? {30'h0, range_reg}                 :
        hit_gn  ? {17'h0, gain_reg}                  :
        hit_ofs ? {17'h0, offset_reg}                :
        hit_bw  ? {29'h0, bw_reg}                    :
        hit_tr  ? {20'h0, tref_reg}                  :
        hit_t1  ? {16'h0, coef1_reg}                 :
        hit_t2  ? {16'h0, coef2_reg}                 :
        hit_st  ? status_word                        :
        hit_dac ? {20'h0, dac_reg}                   :
        hit_ge  ? 32'(geff_reg)                      :
                  32'h0000_0000;

    // One wait state, then the request is completed
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wait_reg <= ~(req & wait_reg);
            if (req & wait_reg)
                rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o    = rdata_reg;

    // Setting registers
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            range_reg  <= RANGE_RST;
            gain_reg   <= GAIN_RST;
            offset_reg <= OFFSET_RST;
            bw_reg     <= BW_RST;
            tref_reg   <= TREF_RST;
            coef1_reg  <= TC_RST;
            coef2_reg  <= TC_RST;
        end
        else if (wr_en)
        begin
            if (hit_rng)
                range_reg <= wmerge_rng[RANGE_W-1:0];
            if (hit_gn)
                gain_reg <= wmerge_gn[SET_W-1:0];
            if (hit_ofs)
                offset_reg <= wmerge_ofs[SET_W-1:0];
            if (hit_bw)
                bw_reg <= wmerge_bw[BW_W-1:0];
            if (hit_tr)
                tref_reg <= wmerge_tr[TEMP_W-1:0];
            if (hit_t1)
                coef1_reg <= wmerge_t1[COEF_W-1:0];
            if (hit_t2)
                coef2_reg <= wmerge_t2[COEF_W-1:0];
        end
    end

    // Converter span follows the range setting
    assign adc_range_o = range_reg;

    // Temperature compensation arithmetic
    wire signed [TEMP_W:0] dt_next =
        $signed({1'b0, temp_data_i}) - $signed({1'b0, tref_reg});
    wire signed [31:0] lin_next = $signed(coef1_reg) * dt_reg;
    wire signed [31:0] sq_next  = dt_reg * dt_reg;
    wire signed [31:0] sq_sh    = sq_reg >>> SQ_SHIFT;
    wire signed [31:0] quad_next = $signed(coef2_reg) * sq_sh;
    wire signed [31:0] raw_gain =
        $signed({17'h0, gain_reg}) - SETTING_BIAS;
    wire signed [31:0] geff_sum = raw_gain + (lin_reg >>> LIN_SHIFT)
                                + (quad_reg >>> QUAD_SHIFT);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dt_reg       <= '0;
            dt_vld_reg   <= 1'b0;
            lin_reg      <= '0;
            sq_reg       <= '0;
            mul_vld_reg  <= 1'b0;
            quad_reg     <= '0;
            quad_vld_reg <= 1'b0;
            geff_reg     <= GEFF_W'(32'(GAIN_RST) - SETTING_BIAS);
        end
        else
        begin
            dt_vld_reg   <= temp_valid_i;
            mul_vld_reg  <= dt_vld_reg;
            quad_vld_reg <= mul_vld_reg;
            if (temp_valid_i)
                dt_reg <= dt_next;
            if (dt_vld_reg)
            begin
                lin_reg <= lin_next;
                sq_reg  <= sq_next;
            end
            if (mul_vld_reg)
                quad_reg <= quad_next;
            if (quad_vld_reg)
                geff_reg <= GEFF_W'(geff_sum);
        end
    end

    // Input filter
    hsp_lowpass u_lowpass
    (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .x_i       ($signed(hall_data_i)),
        .x_valid_i (hall_valid_i),
        .sel_i     (bw_reg),
        .y_o       (lpf_y)
    );

    // 16 kHz sample tick; a tick waits while the buffer is full
    wire tick     = (tick_cnt_reg == CNT_W'(DECIM - 1));
    wire fifo_push = pend_reg & fifo_in_ready;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tick_cnt_reg <= '0;
            pend_reg     <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick ? '0 : CNT_W'(tick_cnt_reg + 1'b1);
            if (tick)
                pend_reg <= 1'b1;
            else if (fifo_push)
                pend_reg <= 1'b0;
        end
    end

    hsp_fifo
    #(
        .WIDTH (HALL_W),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (lpf_y),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (state_reg == ST_IDLE),
        .count_o     (fifo_count)
    );

    // Field datapath sequencing
    wire dac_free = ~dac_vld_reg | dac_ready_i;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (fifo_out_valid)
                    state_next = ST_MUL;
            ST_MUL:
                state_next = ST_ADD;
            ST_ADD:
                state_next = ST_OUT;
            ST_OUT:
                if (dac_free)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    wire signed [PROD_W:0] scaled  = (PROD_W+1)'(prod_reg >>> GAIN_FRAC);
    wire signed [PROD_W:0] ofs_term =
        (PROD_W+1)'($signed({2'b00, offset_reg}) - SETTING_BIAS);
    wire        [DAC_W-1:0] limited =
        (sum_reg < 0)                        ? '0 :
        (sum_reg > (PROD_W+1)'(DAC_MAX))     ? DAC_W'(DAC_MAX) :
                                               sum_reg[DAC_W-1:0];

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg   <= ST_IDLE;
            x_reg       <= '0;
            gain_hold_reg <= '0;
            prod_reg    <= '0;
            sum_reg     <= '0;
            dac_reg     <= '0;
            dac_vld_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && fifo_out_valid)
            begin
                x_reg      <= $signed(fifo_data);
                gain_hold_reg <= geff_reg;
            end
            if (state_reg == ST_MUL)
                prod_reg <= x_reg * gain_hold_reg;
            if (state_reg == ST_ADD)
                sum_reg <= scaled + ofs_term;
            if (state_reg == ST_OUT && dac_free)
            begin
                dac_reg     <= limited;
                dac_vld_reg <= 1'b1;
            end
            else if (dac_ready_i)
                dac_vld_reg <= 1'b0;
        end
    end

    assign dac_code_o  = dac_reg;
    assign dac_valid_o = dac_vld_reg;

endmodule : hsp_signal_path

//--- hdl/hsp_pkg.sv
package hsp_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_RANGE    = 8'h00;
    localparam logic [7:0] ADDR_GAIN     = 8'h04;
    localparam logic [7:0] ADDR_OFFSET   = 8'h08;
    localparam logic [7:0] ADDR_LOWPASS  = 8'h0C;
    localparam logic [7:0] ADDR_TREF     = 8'h10;
    localparam logic [7:0] ADDR_COEF1    = 8'h14;
    localparam logic [7:0] ADDR_COEF2    = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_DAC      = 8'h20;
    localparam logic [7:0] ADDR_GEFF     = 8'h24;

    // Field widths
    localparam int RANGE_W = 2;
    localparam int SET_W   = 15;
    localparam int BW_W    = 3;
    localparam int TEMP_W  = 12;
    localparam int COEF_W  = 16;
    localparam int HALL_W  = 16;
    localparam int DAC_W   = 12;
    localparam int GEFF_W  = 24;

    // Reset values
    localparam logic [RANGE_W-1:0] RANGE_RST  = 2'h1;
    localparam logic [SET_W-1:0]   GAIN_RST   = 15'h5000;
    localparam logic [SET_W-1:0]   OFFSET_RST = 15'h4800;
    localparam logic [BW_W-1:0]    BW_RST     = 3'h0;
    localparam logic [TEMP_W-1:0]  TREF_RST   = 12'h000;
    localparam logic [COEF_W-1:0]  TC_RST     = 16'h0000;

    // Range codes
    localparam logic [RANGE_W-1:0] RANGE_50MT  = 2'h3;
    localparam logic [RANGE_W-1:0] RANGE_100MT = 2'h1;
    localparam logic [RANGE_W-1:0] RANGE_200MT = 2'h0;

    // Arithmetic constants
    localparam int SETTING_BIAS = 16384;
    localparam int GAIN_FRAC    = 12;
    localparam int LIN_SHIFT    = 10;
    localparam int SQ_SHIFT     = 12;
    localparam int QUAD_SHIFT   = 8;
    localparam int DAC_MAX      = 4095;
    localparam logic [BW_W-1:0] BW_BYPASS = 3'h7;
    localparam int LPF_FRAC     = 8;

    // Timing
    localparam int CLK_HZ       = 250_000_000;
    localparam int LPF_RATE_HZ  = 16_000;
    localparam int DECIM_CYCLES = CLK_HZ / LPF_RATE_HZ;

    // Buffer
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MUL  = 4'b0010,
        ST_ADD  = 4'b0100,
        ST_OUT  = 4'b1000
    } hsp_state_e;

endpackage : hsp_pkg

//--- hdl/hsp_fifo.sv
`timescale 1ns/1ps
module hsp_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign count_o     = count_reg;

    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            if (pop)
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            if (push && !pop)
                count_reg <= (AW+1)'(count_reg + 1'b1);
            else if (pop && !push)
                count_reg <= (AW+1)'(count_reg - 1'b1);
        end
    end

endmodule : hsp_fifo

//--- hdl/hsp_lowpass.sv
`timescale 1ns/1ps
module hsp_lowpass
    import hsp_pkg::*;
(
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    input  wire logic signed [HALL_W-1:0] x_i,
    input  wire logic                     x_valid_i,
    input  wire logic        [BW_W-1:0]   sel_i,
    output logic signed      [HALL_W-1:0] y_o
);
    localparam int ACC_W = HALL_W + LPF_FRAC;

    logic signed [ACC_W-1:0] acc_reg;
    wire  signed [ACC_W-1:0] x_ext  = ACC_W'(x_i) <<< LPF_FRAC;
    wire  signed [ACC_W:0]   diff   = (ACC_W+1)'(x_ext) - (ACC_W+1)'(acc_reg);
    wire         [2:0]       shift  = 3'(BW_BYPASS - sel_i);
    wire  signed [ACC_W:0]   step   = diff >>> shift;
    wire  signed [ACC_W-1:0] acc_next = (sel_i == BW_BYPASS) ? x_ext
                                      : ACC_W'(acc_reg + step[ACC_W-1:0]);

    assign y_o = acc_reg[ACC_W-1:LPF_FRAC];

    // First order section: unity DC gain, setting 7 passes samples through
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            acc_reg <= '0;
        else if (x_valid_i)
            acc_reg <= acc_next;
    end

endmodule : hsp_lowpass

//--- tb/hsp_dac_model.sv
`timescale 1ns/1ps
module hsp_dac_model
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [11:0] code_i,
    input  wire logic        valid_i,
    input  wire logic        stall_i,
    output logic             ready_o,
    output logic      [11:0] last_o,
    output logic      [15:0] count_o
);
    // Converter takes a word only while not stalled
    assign ready_o = !stall_i;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            last_o  <= 12'h000;
            count_o <= 16'h0000;
        end
        else if (valid_i && ready_o)
        begin
            last_o  <= code_i;
            count_o <= count_o + 16'h0001;
        end
    end
endmodule : hsp_dac_model

//--- tb/hsp_signal_path_asserts.sv
`timescale 1ns/1ps
module hsp_signal_path_asserts
    import hsp_pkg::*;
#(
    parameter int DECIM = 16
)
(
    input wire logic               mclk_i,
    input wire logic               rst_n_i,
    input wire logic [7:0]         avs_address_i,
    input wire logic               avs_read_i,
    input wire logic               avs_write_i,
    input wire logic [31:0]        avs_writedata_i,
    input wire logic [31:0]        avs_readdata_o,
    input wire logic               avs_waitrequest_o,
    input wire logic [RANGE_W-1:0] adc_range_o,
    input wire logic [DAC_W-1:0]   dac_code_o,
    input wire logic               dac_valid_o,
    input wire logic               dac_ready_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0] rng_w;
    wire        wr_done = avs_write_i && !avs_waitrequest_o;
    wire        rng_hit = wr_done && avs_address_i == ADDR_RANGE;
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i)
            rng_w <= RANGE_RST;
        else if (rng_hit)
            rng_w <= avs_writedata_i[1:0];
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ans;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property p_one_wait;
        s_req |=> s_ans;
    endproperty
    property p_idle;
        !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
    endproperty
    property p_unmapped;
        avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h3C
            |-> avs_readdata_o == 32'h0000_0000;
    endproperty
    property p_rd_hold;
        !((avs_read_i || avs_write_i) && avs_waitrequest_o)
            |=> $stable(avs_readdata_o);
    endproperty
    property p_range;
        rng_hit |-> ##[1:2] adc_range_o == rng_w;
    endproperty
    property p_range_rst;
        $rose(rst_n_i) |-> adc_range_o == RANGE_RST && !dac_valid_o;
    endproperty
    property p_hold;
        dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_code_o);
    endproperty
    property p_fall;
        $fell(dac_valid_o) |-> $past(dac_ready_i);
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer not after one wait state");
    a_idle: assert property (p_idle)
        else $error("waitrequest low without request");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without request");
    a_range: assert property (p_range)
        else $error("range output not the written code");
    a_range_rst: assert property (p_range_rst)
        else $error("range or valid wrong after reset");
    a_hold: assert property (p_hold)
        else $error("DAC word dropped while stalled");
    a_fall: assert property (p_fall)
        else $error("DAC valid fell without ready");
endmodule : hsp_signal_path_asserts
bind hsp_signal_path hsp_signal_path_asserts #(.DECIM(DECIM)) u_chk
(
    .mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .adc_range_o,
    .dac_code_o, .dac_valid_o, .dac_ready_i
);

//--- tb/test_hsp_signal_path.sv
`timescale 1ns/1ps
module test_hsp_signal_path;
    import hsp_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [15:0] hall = 16'h0000;
    logic        hv = 1'b0;
    logic [11:0] temp = 12'h000;
    logic        tv = 1'b0;
    logic        stall = 1'b0;
    logic [31:0] rdat, q;
    logic        wreq, dv, drdy;
    logic [1:0]  rng;
    logic [11:0] code, last;
    logic [15:0] nacc, n0;
    int          err_total = 0;
    int          checked = 0;
    logic [7:0]  ra [9] = '{ADDR_RANGE, ADDR_GAIN, ADDR_OFFSET, ADDR_LOWPASS,
                        ADDR_TREF, ADDR_COEF1, ADDR_COEF2, 8'h3C, ADDR_GEFF};
    logic [15:0] rv [9] = '{16'h0001, 16'h5000, 16'h4800, 16'h0000, 16'h0000,
                           16'h0000, 16'h0000, 16'h0000, 16'h1000};
    logic [1:0]  rc [3] = '{RANGE_50MT, RANGE_100MT, RANGE_200MT};
    // Gain, offset, sample, expected code
    logic [15:0] gt [8][4] = '{'{16'h5000, 16'h4800, 16'h0064, 16'h0864},
        '{16'h3000, 16'h4800, 16'h0064, 16'h079C},
        '{16'h4800, 16'h4001, 16'h0065, 16'h0033},
        '{16'h6000, 16'h4000, 16'h03E8, 16'h07D0},
        '{16'h5000, 16'h0000, 16'h0064, 16'h0000},
        '{16'h5000, 16'h7FFF, 16'h0064, 16'h0FFF},
        '{16'h5000, 16'h4000, 16'hFFCE, 16'h0000},
        '{16'h6000, 16'h4000, 16'h7FFF, 16'h0FFF}};
    // Reference, temperature, linear, square, expected gain
    logic [15:0] tt [4][5] = '{
        '{16'h0000, 16'h0064, 16'hFC00, 16'h0000, 16'h0F9C},
        '{16'h0064, 16'h0190, 16'h0400, 16'h0000, 16'h112C},
        '{16'h0064, 16'h0190, 16'h0000, 16'h0100, 16'h1015},
        '{16'h0064, 16'h0000, 16'h0400, 16'h0100, 16'h0F9E}};
    hsp_signal_path #(.DECIM(16)) u_dut
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .hall_data_i(hall), .hall_valid_i(hv),
        .temp_data_i(temp), .temp_valid_i(tv), .adc_range_o(rng),
        .dac_code_o(code), .dac_valid_o(dv), .dac_ready_i(drdy)
    );
    hsp_dac_model u_dac
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .code_i(code), .valid_i(dv),
        .stall_i(stall), .ready_o(drdy), .last_o(last), .count_o(nacc)
    );
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) hv <= ~hv;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        rd  <= ~w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (wreq !== 1'b0 && n < 40);
        if (n >= 40) err_total++;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic waitc(input int k);
        int base, n;
        base = nacc;
        n = 0;
        while (nacc < base + k && n < 2000)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 2000) err_total++;
    endtask : waitc
    task automatic tpulse(input logic [11:0] v);
        @(posedge mclk_i);
        temp <= v;
        tv   <= 1'b1;
        @(posedge mclk_i);
        tv   <= 1'b0;
        repeat (6) @(posedge mclk_i);
    endtask : tpulse
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100_000;
        err_total++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
        foreach (ra[i])
        begin
            bus(1'b0, ra[i], 32'h0000_0000);
            chk(q, {16'h0000, rv[i]});
        end
        $display("reset values done");
        foreach (rc[i])
        begin
            bus(1'b1, ADDR_RANGE, {30'h0000_0000, rc[i]});
            repeat (2) @(posedge mclk_i);
            chk(rng, rc[i]);
        end
        bus(1'b1, ADDR_GAIN, 32'h0000_0000);
        tpulse(12'h000);
        bus(1'b0, ADDR_GEFF, 32'h0000_0000);
        chk(q, 32'hFFFF_C000);
        $display("range and gain bias done");
        bus(1'b1, ADDR_LOWPASS, 32'h0000_0007);
        foreach (gt[i])
        begin
            hall <= gt[i][2];
            bus(1'b1, ADDR_GAIN, {16'h0000, gt[i][0]});
            bus(1'b1, ADDR_OFFSET, {16'h0000, gt[i][1]});
            tpulse(12'h000);
            waitc(3);
            chk(last, gt[i][3]);
        end
        $display("gain and offset done");
        bus(1'b1, ADDR_GAIN, 32'h0000_5000);
        foreach (tt[i])
        begin
            bus(1'b1, ADDR_TREF, {16'h0000, tt[i][0]});
            bus(1'b1, ADDR_COEF1, {16'h0000, tt[i][2]});
            bus(1'b1, ADDR_COEF2, {16'h0000, tt[i][3]});
            tpulse(tt[i][1][11:0]);
            bus(1'b0, ADDR_GEFF, 32'h0000_0000);
            chk(q, {16'h0000, tt[i][4]});
        end
        tpulse(12'h064);
        $display("temperature compensation done");
        stall <= 1'b1;
        repeat (200) @(posedge mclk_i);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(q[3:0], 4'h8);
        chk(dv, 1'b1);
        stall <= 1'b0;
        repeat (100) @(posedge mclk_i);
        n0 = nacc;
        repeat (320) @(posedge mclk_i);
        chk(nacc - n0, 16'h0014);
        $display("buffer and rate done");
        hall <= 16'h0000;
        repeat (4) @(posedge mclk_i);
        bus(1'b1, ADDR_LOWPASS, 32'h0000_0000);
        hall <= 16'h03E8;
        waitc(2);
        chk(last < 12'h3E8, 1'b1);
        repeat (6000) @(posedge mclk_i);
        waitc(1);
        chk(last >= 12'h3E7, 1'b1);
        $display("low pass done");
        print_verdict();
    end
endmodule : test_hsp_signal_path
